// >>> src/mar_params.svh
// constants for the move-and-return execution unit: encodings, field positions, reset values
// assumes a 14-bit instruction word delivered on the core instruction clock
//
// Contract
// RULE1: direct store copies accumulator into file register 0..127, no flags touched.
// RULE2: indirect store writes accumulator at address derived from one of two pointers.
// RULE3: mode field 00 preinc, 01 predec, 10 postinc, 11 postdec.
// RULE4: relative form adds signed offset -32..31 to pointer for target address.
// RULE5: pointer ends plus one on increments, minus one on decrements, unchanged relative.
// RULE6: each 16-bit pointer wraps modulo 0000h..FFFFh.
// RULE7: indirect port addresses are not storage; access goes to the pointer's address.
// RULE8: indirect store and pointer stepping change no status flag, wrap included.
// RULE9: option load copies accumulator into option register, one word, one cycle.
// RULE10: software reset triggers device reset and clears the reset-instruction flag.
// RULE11: interrupt return pops stack into program counter, two cycles, no flags.
// RULE12: interrupt return also sets global interrupt enable, bit 7 of control register.
// RULE13: subroutine return pops stack into program counter, two cycles, nothing else.
// RULE14: no-operation takes one cycle, advances the counter, changes nothing.
`ifndef MAR_PARAMS_SVH
`define MAR_PARAMS_SVH

// ----------------------------------------------------------------
// instruction word layout
// ----------------------------------------------------------------
`define MAR_CLASS_HI 13
`define MAR_CLASS_LO 11
`define MAR_CLASS_MISC 3'h0
`define MAR_CLASS_DIRECT 3'h1
`define MAR_CLASS_IND_MODE 3'h2
`define MAR_CLASS_IND_REL 3'h3
`define MAR_SUB_NOP 3'h0
`define MAR_SUB_OPTION 3'h1
`define MAR_SUB_RESET 3'h2
`define MAR_SUB_RETURN 3'h3
`define MAR_SUB_RET_INT 3'h4
`define MAR_MODE_SEL_BIT 2
`define MAR_REL_SEL_BIT 6

// ----------------------------------------------------------------
// addresses, bit positions and reset values
// ----------------------------------------------------------------
`define MAR_IND_PORT0_ADDR 7'h00
`define MAR_IND_PORT1_ADDR 7'h01
`define MAR_INT_EN_BIT 7
`define MAR_OPTION_RESET 8'hFF
`define MAR_PTR_RESET 16'h0000
`define MAR_RETURN_CYCLES 2

`endif

// >>> src/mar_pkg.sv
// types shared by the move-and-return execution unit
// assumes mar_params.svh supplies the numeric constants
package mar_pkg;

  // decoded operation
  typedef enum logic [2:0] {
    MAR_OP_NOP = 3'b000,
    MAR_OP_OPTION = 3'b001,
    MAR_OP_RESET = 3'b010,
    MAR_OP_RETURN = 3'b011,
    MAR_OP_RET_INT = 3'b100,
    MAR_OP_DIRECT = 3'b101,
    MAR_OP_INDIRECT = 3'b110,
    MAR_OP_OTHER = 3'b111
  } mar_op_t;

  // execution sequencer
  typedef enum logic [0:0] {
    MAR_ST_IDLE = 1'b0,
    MAR_ST_RET2 = 1'b1
  } mar_state_t;

  // decoded instruction fields
  typedef struct packed {
    mar_op_t op;
    logic [6:0] faddr;
    logic psel;
    logic [1:0] pointer_update_mode;
    logic rel;
    logic [5:0] offset;
  } mar_decode_t;

  // data memory write request
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } mar_dm_wr_t;

endpackage

// >>> src/mar_ptr_unit.sv
// the two file-select pointers with their effective-address and step logic
// assumes one update request per cycle from the execution unit
`timescale 1ns/1ps
`include "mar_params.svh"
module mar_ptr_unit (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // update from an indirect store
  input wire logic upd_en,
  input wire logic upd_sel,
  input wire logic [1:0] upd_mode,
  input wire logic upd_rel,
  input wire logic [5:0] upd_offset,
  // plain load from other core logic
  input wire logic load_en,
  input wire logic load_sel,
  input wire logic [15:0] load_value,
  // pointer values and effective address of the selected pointer
  output logic [1:0][15:0] file_select_pointer,
  output logic [15:0] eff_addr
);
  import mar_pkg::*;

  logic [15:0] sel_ptr;
  logic [15:0] step_ptr;
  logic [15:0] sext_offset;

  // selected pointer and its effective address; 16-bit arithmetic wraps by itself
  assign sel_ptr = file_select_pointer[upd_sel];
  assign sext_offset = {{10{upd_offset[5]}}, upd_offset};
  assign step_ptr = upd_mode[0] ? 16'(sel_ptr - 16'h0001) : 16'(sel_ptr + 16'h0001); // [RULE6]
  always_comb begin
    if (upd_rel) begin
      eff_addr = 16'(sel_ptr + sext_offset); // [RULE4]
    end else if (!upd_mode[1]) begin
      eff_addr = step_ptr; // [RULE3] pre forms use the stepped value
    end else begin
      eff_addr = sel_ptr; // [RULE3] post forms use the old value
    end
  end

  // one register per pointer; a core load wins over a step in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ptr
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          file_select_pointer[gi] <= `MAR_PTR_RESET;
        end else if (load_en && (load_sel == 1'(gi))) begin
          file_select_pointer[gi] <= load_value;
        end else if (upd_en && !upd_rel && (upd_sel == 1'(gi))) begin
          file_select_pointer[gi] <= step_ptr; // [RULE5]
        end
      end
    end
  endgenerate

endmodule

// >>> src/mar_exec.sv
// execution unit for direct/indirect accumulator stores, option load,
// software reset and the two return instructions
// assumes accumulator, stack top and control register come from core logic on clk
`timescale 1ns/1ps
`include "mar_params.svh"
module mar_exec (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction handshake
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  // core operands
  input wire logic [7:0] w_acc,
  input wire logic [4:0] bank_select,
  input wire logic [14:0] top_of_stack,
  input wire logic [7:0] interrupt_control_register,
  // pointer load from other instructions
  input wire logic ptr_load_en,
  input wire logic ptr_load_sel,
  input wire logic [15:0] ptr_load_value,
  // address resolution for other file accesses
  input wire logic [6:0] ext_faddr,
  output logic [15:0] ext_resolved_addr,
  // software sets the reset-instruction flag back
  input wire logic ri_flag_set,
  // data memory write
  output mar_pkg::mar_dm_wr_t dm_wr,
  // program counter and stack
  output logic pc_advance,
  output logic pc_load,
  output logic [14:0] pc_load_value,
  output logic stack_pop,
  // control and status
  output logic int_ctrl_we,
  output logic [7:0] int_ctrl_wdata,
  output logic status_we,
  output logic [7:0] option_reg,
  output logic reset_instr_flag_n,
  output logic sw_reset_req,
  output logic [1:0][15:0] file_select_pointer
);
  import mar_pkg::*;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------

  // split the word into fields; unknown words decode as other and are ignored here
  function automatic mar_decode_t decode(input logic [13:0] iw);
    mar_decode_t d;
    d = '0;
    d.op = MAR_OP_OTHER;
    d.faddr = iw[6:0];
    d.offset = iw[5:0];
    case (iw[`MAR_CLASS_HI:`MAR_CLASS_LO])
      `MAR_CLASS_MISC: begin
        case (iw[2:0])
          `MAR_SUB_NOP: d.op = MAR_OP_NOP;
          `MAR_SUB_OPTION: d.op = MAR_OP_OPTION;
          `MAR_SUB_RESET: d.op = MAR_OP_RESET;
          `MAR_SUB_RETURN: d.op = MAR_OP_RETURN;
          `MAR_SUB_RET_INT: d.op = MAR_OP_RET_INT;
          default: d.op = MAR_OP_OTHER;
        endcase
      end
      `MAR_CLASS_DIRECT: d.op = MAR_OP_DIRECT;
      `MAR_CLASS_IND_MODE: begin
        d.op = MAR_OP_INDIRECT;
        d.psel = iw[`MAR_MODE_SEL_BIT];
        d.pointer_update_mode = iw[1:0];
      end
      `MAR_CLASS_IND_REL: begin
        d.op = MAR_OP_INDIRECT;
        d.rel = 1'b1;
        d.psel = iw[`MAR_REL_SEL_BIT];
      end
      default: d.op = MAR_OP_OTHER;
    endcase
    return d;
  endfunction

  // file address to data address; the indirect ports map onto the pointers
  function automatic logic [15:0] resolve(input logic [6:0] f, input logic [4:0] bank,
                                          input logic [15:0] p0, input logic [15:0] p1);
    if (f == `MAR_IND_PORT0_ADDR) begin
      return p0; // [RULE7]
    end else if (f == `MAR_IND_PORT1_ADDR) begin
      return p1; // [RULE7]
    end else begin
      return {4'h0, bank, f};
    end
  endfunction

  mar_state_t state_reg;
  mar_state_t state_next;
  mar_decode_t dec;
  logic accept;
  logic ind_upd;
  logic [15:0] ptr_eff_addr;

  assign dec = decode(instr_word);
  assign instr_ready = (state_reg == MAR_ST_IDLE);
  assign accept = instr_valid && instr_ready;
  assign ind_upd = accept && (dec.op == MAR_OP_INDIRECT);
  assign ext_resolved_addr = resolve(ext_faddr, bank_select, file_select_pointer[0],
                                     file_select_pointer[1]); // [RULE7]

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------

  // pointer stepping is plain arithmetic here; nothing reaches the status flags
  mar_ptr_unit u_ptr (
    .clk(clk),
    .arst_n(arst_n),
    .upd_en(ind_upd), // [RULE5]
    .upd_sel(dec.psel),
    .upd_mode(dec.pointer_update_mode),
    .upd_rel(dec.rel),
    .upd_offset(dec.offset),
    .load_en(ptr_load_en),
    .load_sel(ptr_load_sel),
    .load_value(ptr_load_value),
    .file_select_pointer(file_select_pointer),
    .eff_addr(ptr_eff_addr)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------

  // returns hold the handshake low for their second cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MAR_ST_IDLE: begin
        if (accept && (dec.op == MAR_OP_RETURN || dec.op == MAR_OP_RET_INT)) begin
          state_next = MAR_ST_RET2; // [RULE11] [RULE13]
        end
      end
      MAR_ST_RET2: state_next = MAR_ST_IDLE;
      default: state_next = MAR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= MAR_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // data memory writes
  // ----------------------------------------------------------------

  // one registered write per store; the address is resolved in the issue cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dm_wr <= '0;
    end else begin
      dm_wr.we <= 1'b0;
      if (accept && dec.op == MAR_OP_DIRECT) begin
        dm_wr.we <= 1'b1; // [RULE1]
        dm_wr.addr <= resolve(dec.faddr, bank_select, file_select_pointer[0],
                              file_select_pointer[1]);
        dm_wr.data <= w_acc;
      end else if (ind_upd) begin
        dm_wr.we <= 1'b1; // [RULE2]
        dm_wr.addr <= ptr_eff_addr;
        dm_wr.data <= w_acc;
      end
    end
  end

  // ----------------------------------------------------------------
  // program counter and stack
  // ----------------------------------------------------------------

  // nop, option load and direct/indirect stores advance; returns pop and load instead
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_advance <= 1'b0;
      pc_load <= 1'b0;
      stack_pop <= 1'b0;
      pc_load_value <= '0;
    end else begin
      pc_advance <= accept && (dec.op == MAR_OP_NOP || dec.op == MAR_OP_OPTION ||
                               dec.op == MAR_OP_DIRECT || dec.op == MAR_OP_INDIRECT); // [RULE14]
      pc_load <= 1'b0;
      stack_pop <= 1'b0;
      if (accept && (dec.op == MAR_OP_RETURN || dec.op == MAR_OP_RET_INT)) begin
        pc_load <= 1'b1; // [RULE11] [RULE13]
        stack_pop <= 1'b1;
        pc_load_value <= top_of_stack;
      end
    end
  end

  // interrupt return writes the control register with the enable bit forced high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_ctrl_we <= 1'b0;
      int_ctrl_wdata <= '0;
    end else begin
      int_ctrl_we <= accept && (dec.op == MAR_OP_RET_INT);
      if (accept && (dec.op == MAR_OP_RET_INT)) begin
        int_ctrl_wdata <= interrupt_control_register | (8'h01 << `MAR_INT_EN_BIT); // [RULE12]
      end
    end
  end

  // none of these instructions touch the flags, pointer wrap included
  assign status_we = 1'b0; // [RULE8]

  // ----------------------------------------------------------------
  // option register and software reset
  // ----------------------------------------------------------------

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      option_reg <= `MAR_OPTION_RESET;
    end else if (accept && dec.op == MAR_OP_OPTION) begin
      option_reg <= w_acc; // [RULE9]
    end
  end

  // the flag survives the requested reset only if the reset generator spares
  // this block; arst_n is taken as the power-on reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_instr_flag_n <= 1'b1;
      sw_reset_req <= 1'b0;
    end else begin
      sw_reset_req <= accept && (dec.op == MAR_OP_RESET); // [RULE10]
      if (accept && dec.op == MAR_OP_RESET) begin
        reset_instr_flag_n <= 1'b0; // [RULE10] clear wins over a set
      end else if (ri_flag_set) begin
        reset_instr_flag_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [15:0] sel_ptr;
  assign sel_ptr = file_select_pointer[dec.psel];

  property p_direct;
    accept && dec.op == MAR_OP_DIRECT && dec.faddr > 7'h01 |=>
      dm_wr.we && dm_wr.addr == {4'h0, $past(bank_select), $past(dec.faddr)} &&
      dm_wr.data == $past(w_acc);
  endproperty
  a_direct: assert property (p_direct) else $error("direct store wrong"); // [RULE1]

  property p_ind_port;
    accept && dec.op == MAR_OP_DIRECT && dec.faddr == `MAR_IND_PORT1_ADDR |=>
      dm_wr.we && dm_wr.addr == $past(file_select_pointer[1]);
  endproperty
  a_ind_port: assert property (p_ind_port) else $error("port not redirected"); // [RULE7]

  property p_preinc;
    ind_upd && !dec.rel && dec.pointer_update_mode == 2'b00 |=>
      dm_wr.we && dm_wr.data == $past(w_acc) && dm_wr.addr == 16'($past(sel_ptr) + 16'h0001);
  endproperty
  a_preinc: assert property (p_preinc) else $error("preinc address wrong"); // [RULE2]

  property p_postdec;
    ind_upd && !dec.rel && dec.pointer_update_mode == 2'b11 && !ptr_load_en |=>
      dm_wr.addr == $past(sel_ptr) &&
      file_select_pointer[$past(dec.psel)] == 16'($past(sel_ptr) - 16'h0001);
  endproperty
  a_postdec: assert property (p_postdec) else $error("postdec wrong"); // [RULE3]

  property p_rel;
    ind_upd && dec.rel && !ptr_load_en |=>
      dm_wr.addr == 16'($past(sel_ptr) + {{10{$past(dec.offset[5])}}, $past(dec.offset)}) &&
      file_select_pointer[$past(dec.psel)] == $past(sel_ptr);
  endproperty
  a_rel: assert property (p_rel) else $error("relative store wrong"); // [RULE4] [RULE5]

  property p_wrap;
    ind_upd && !dec.rel && !dec.pointer_update_mode[0] && sel_ptr == 16'hFFFF &&
      !ptr_load_en |=> file_select_pointer[$past(dec.psel)] == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // [RULE6]

  property p_no_flags;
    !status_we;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("status written"); // [RULE8]

  property p_option;
    accept && dec.op == MAR_OP_OPTION |=> option_reg == $past(w_acc) && pc_advance && instr_ready;
  endproperty
  a_option: assert property (p_option) else $error("option load wrong"); // [RULE9]

  property p_reset;
    accept && dec.op == MAR_OP_RESET |=> sw_reset_req && !reset_instr_flag_n ##1
      sw_reset_req == $past(accept && dec.op == MAR_OP_RESET);
  endproperty
  a_reset: assert property (p_reset) else $error("software reset wrong"); // [RULE10]

  property p_ret_int;
    accept && dec.op == MAR_OP_RET_INT |=>
      stack_pop && pc_load && pc_load_value == $past(top_of_stack) && !instr_ready &&
      int_ctrl_we && int_ctrl_wdata[`MAR_INT_EN_BIT] ##1 instr_ready && !stack_pop;
  endproperty
  a_ret_int: assert property (p_ret_int) else $error("int return wrong"); // [RULE11] [RULE12]

  property p_return;
    accept && dec.op == MAR_OP_RETURN |=>
      stack_pop && pc_load && pc_load_value == $past(top_of_stack) && !int_ctrl_we &&
      !instr_ready ##1 instr_ready;
  endproperty
  a_return: assert property (p_return) else $error("subroutine return wrong"); // [RULE13]

  property p_nop;
    accept && dec.op == MAR_OP_NOP |=> pc_advance && !dm_wr.we && !stack_pop && instr_ready;
  endproperty
  a_nop: assert property (p_nop) else $error("nop had an effect"); // [RULE14]

endmodule

// >>> tb/mar_exec_tb_top.sv
// self-checking bench for the move-and-return execution unit
// assumes mar_pkg compiled first; drives every input itself at the falling edge
`timescale 1ns/1ps
`include "mar_params.svh"
module mar_exec_tb_top;
  import mar_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic instr_ready;
  logic [7:0] w_acc = 8'h00;
  logic [4:0] bank_select = 5'h03;
  logic [14:0] top_of_stack = 15'h0000;
  logic [7:0] interrupt_control_register = 8'h05;
  logic ptr_load_en = 1'b0;
  logic ptr_load_sel = 1'b0;
  logic [15:0] ptr_load_value = 16'h0000;
  logic [6:0] ext_faddr = 7'h10;
  logic [15:0] ext_resolved_addr;
  logic ri_flag_set = 1'b0;
  mar_dm_wr_t dm_wr;
  logic pc_advance, pc_load, stack_pop, int_ctrl_we, status_we, reset_instr_flag_n, sw_reset_req;
  logic [14:0] pc_load_value;
  logic [7:0] int_ctrl_wdata, option_reg;
  logic [1:0][15:0] file_select_pointer;
  logic [15:0] exp_ptr [2];
  int error_cnt = 0;
  int n_compared = 0;

  // 250 MHz core clock
  always #2 clk = ~clk;

  mar_exec u_mar_exec (
    .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .w_acc(w_acc), .bank_select(bank_select),
    .top_of_stack(top_of_stack), .interrupt_control_register(interrupt_control_register),
    .ptr_load_en(ptr_load_en), .ptr_load_sel(ptr_load_sel), .ptr_load_value(ptr_load_value),
    .ext_faddr(ext_faddr), .ext_resolved_addr(ext_resolved_addr), .ri_flag_set(ri_flag_set),
    .dm_wr(dm_wr), .pc_advance(pc_advance), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .stack_pop(stack_pop), .int_ctrl_we(int_ctrl_we), .int_ctrl_wdata(int_ctrl_wdata),
    .status_we(status_we), .option_reg(option_reg), .reset_instr_flag_n(reset_instr_flag_n),
    .sw_reset_req(sw_reset_req), .file_select_pointer(file_select_pointer)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input bit ok, input string what);
    n_compared++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // present a word from a falling edge; returns at the next falling edge, effects visible
  task automatic issue(input logic [13:0] word);
    instr_valid = 1'b1;
    instr_word = word;
    @(negedge clk);
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic load_ptr(input logic sel, input logic [15:0] val);
    ptr_load_en = 1'b1;
    ptr_load_sel = sel;
    ptr_load_value = val;
    exp_ptr[sel] = val;
    @(negedge clk);
    ptr_load_en = 1'b0;
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // back-to-back indirect stores in every update mode; pointer 0 starts at the wrap edge, pointer 1 at 8000h
  task automatic t_ind_modes();
    logic [15:0] p, a;
    load_ptr(1'b0, 16'hFFFF);
    load_ptr(1'b1, 16'h8000);
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        p = exp_ptr[s];
        a = m[1] ? p : (m[0] ? p - 16'h0001 : p + 16'h0001);
        exp_ptr[s] = m[0] ? p - 16'h0001 : p + 16'h0001;
        w_acc = 8'h50 + 8'(m);
        issue({`MAR_CLASS_IND_MODE, 8'h00, 1'(s), 2'(m)});
        chk(dm_wr.we === 1'b1 && dm_wr.addr === a && dm_wr.data === w_acc, "ind addr");
        chk(file_select_pointer[0] === exp_ptr[0] && file_select_pointer[1] === exp_ptr[1],
            "ind step");
        chk(status_we === 1'b0 && pc_advance === 1'b1, "ind flags");
      end
    end
    idle();
  endtask

  // relative form at both ends of the offset range, pointer left alone
  task automatic t_ind_rel();
    logic [5:0] offs [2];
    offs[0] = 6'h20;
    offs[1] = 6'h1F;
    load_ptr(1'b1, 16'h0100);
    for (int i = 0; i < 2; i++) begin
      w_acc = 8'hC0 + 8'(i);
      issue({`MAR_CLASS_IND_REL, 4'h0, 1'b1, offs[i]});
      chk(dm_wr.we === 1'b1 && dm_wr.addr === (i ? 16'h011F : 16'h00E0), "rel addr");
      chk(file_select_pointer[1] === 16'h0100 && status_we === 1'b0, "rel ptr");
    end
    // a core load on the same pointer beats the step; the store still uses the old pointer
    ptr_load_en = 1'b1;
    ptr_load_sel = 1'b1;
    ptr_load_value = 16'h2222;
    exp_ptr[1] = 16'h2222;
    issue({`MAR_CLASS_IND_MODE, 8'h00, 1'b1, 2'b00});
    ptr_load_en = 1'b0;
    chk(dm_wr.addr === 16'h0101 && file_select_pointer[1] === 16'h2222, "load vs step");
    idle();
  endtask

  // direct store to a plain register and to both indirect ports
  task automatic t_direct();
    w_acc = 8'hA5;
    issue({`MAR_CLASS_DIRECT, 4'h0, 7'h7F});
    chk(dm_wr.we === 1'b1 && dm_wr.addr === {4'h0, 5'h03, 7'h7F} && dm_wr.data === 8'hA5,
        "direct store");
    chk(pc_advance === 1'b1 && status_we === 1'b0, "direct flags");
    issue({`MAR_CLASS_DIRECT, 4'h0, `MAR_IND_PORT0_ADDR});
    chk(dm_wr.we === 1'b1 && dm_wr.addr === exp_ptr[0], "port0 store");
    issue({`MAR_CLASS_DIRECT, 4'h0, `MAR_IND_PORT1_ADDR});
    chk(dm_wr.we === 1'b1 && dm_wr.addr === exp_ptr[1], "port1 store");
    idle();
    chk(dm_wr.we === 1'b0, "store pulse");
    chk(ext_resolved_addr === {4'h0, 5'h03, 7'h10}, "resolve plain");
    ext_faddr = `MAR_IND_PORT1_ADDR;
    @(negedge clk);
    chk(ext_resolved_addr === exp_ptr[1], "resolve port");
  endtask

  // option load, then no-operation and an unknown word back to back
  task automatic t_option_nop();
    w_acc = 8'h4F;
    issue(14'h0001);
    chk(option_reg === 8'h4F && dm_wr.we === 1'b0 && pc_advance === 1'b1, "option");
    w_acc = 8'h11;
    issue(14'h0000);
    chk(option_reg === 8'h4F && dm_wr.we === 1'b0 && pc_advance === 1'b1, "nop");
    chk(file_select_pointer[1] === exp_ptr[1] && stack_pop === 1'b0, "nop state");
    issue(14'h3800);
    chk(pc_advance === 1'b0 && dm_wr.we === 1'b0 && option_reg === 8'h4F, "unknown");
    idle();
  endtask

  // software reset clears the flag; core logic later sets it back
  task automatic t_sw_reset();
    issue(14'h0002);
    chk(sw_reset_req === 1'b1 && reset_instr_flag_n === 1'b0, "sw reset");
    idle();
    chk(sw_reset_req === 1'b0 && reset_instr_flag_n === 1'b0, "flag holds");
    ri_flag_set = 1'b1;
    @(negedge clk);
    ri_flag_set = 1'b0;
    chk(reset_instr_flag_n === 1'b1, "flag set");
    // a reset word and a set in the same cycle: the clear wins
    ri_flag_set = 1'b1;
    issue(14'h0002);
    ri_flag_set = 1'b0;
    chk(reset_instr_flag_n === 1'b0 && sw_reset_req === 1'b1, "clear beats set");
    idle();
  endtask

  // both returns; a no-operation waits through the blocked second cycle
  task automatic t_returns();
    top_of_stack = 15'h1234;
    issue(14'h0003);
    chk(stack_pop === 1'b1 && pc_load === 1'b1 && pc_load_value === 15'h1234, "ret");
    chk(instr_ready === 1'b0 && int_ctrl_we === 1'b0 && status_we === 1'b0, "ret side");
    issue(14'h0000);
    chk(pc_advance === 1'b0 && stack_pop === 1'b0 && instr_ready === 1'b1, "ret wait");
    issue(14'h0000);
    chk(pc_advance === 1'b1, "after ret");
    top_of_stack = 15'h7ABC;
    issue(14'h0004);
    chk(stack_pop === 1'b1 && pc_load === 1'b1 && pc_load_value === 15'h7ABC, "reti");
    chk(int_ctrl_we === 1'b1 && int_ctrl_wdata === 8'h85, "reti en");
    chk(instr_ready === 1'b0, "reti busy");
    chk(int_ctrl_wdata[`MAR_INT_EN_BIT] === 1'b1 && status_we === 1'b0, "enable bit");
    idle();
    chk(int_ctrl_we === 1'b0 && stack_pop === 1'b0, "reti end");
    chk(pc_load_value === 15'h7ABC, "pc value holds");
    chk(instr_ready === 1'b1, "reti ready");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    exp_ptr[0] = `MAR_PTR_RESET;
    exp_ptr[1] = `MAR_PTR_RESET;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk(option_reg === `MAR_OPTION_RESET && reset_instr_flag_n === 1'b1, "reset regs");
    chk(file_select_pointer === {`MAR_PTR_RESET, `MAR_PTR_RESET}, "reset ptr");
    chk(instr_ready === 1'b1, "reset ready");
    t_direct();
    t_ind_modes();
    t_ind_rel();
    t_option_nop();
    t_sw_reset();
    t_returns();
    wrap_up();
  end

  // the whole run needs well under a hundred cycles; a hang is cut short here
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule
